// file: src/timer_channel.sv
// Purpose: One 8-bit count-up timer/event counter channel
// Assumes: Pin input already synchronous; control bits held by the parent
// Notes:   Run bit is owned by the parent, capture end is reported back
`timescale 1ns/1ps
`default_nettype none
module timer_channel (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rst_n,
   input  wire logic [1:0]                    i_op_mode,
   input  wire logic                          i_run,
   input  wire logic                          i_edge_sel,
   input  wire logic [2:0]                    i_psc_ratio,
   input  wire logic                          i_ext_pin,
   input  wire logic                          i_preload_wr,
   input  wire logic [dual_timer_pkg::DATA_W-1:0] i_wdata,
   output logic      [dual_timer_pkg::DATA_W-1:0] o_count,
   output logic                               o_overflow,
   output logic                               o_capture_done
);
   import dual_timer_pkg::*;

   typedef enum logic [2:0] {
      CAP_IDLE   = 3'b001,
      CAP_ARMED  = 3'b010,
      CAP_ACTIVE = 3'b100
   } cap_state_t;

   logic              pin_s1;
   logic              pin_s2;
   logic              pin_s3;
   logic [PSC_W-1:0]  psc_cnt;
   logic [PSC_W-1:0]  next_psc_cnt;
   logic [7:0]        preload;
   logic [7:0]        next_preload;
   logic [7:0]        count;
   logic [7:0]        next_count;
   logic              ovf;
   logic              next_ovf;
   logic              cap_done;
   logic              next_cap_done;
   cap_state_t        cap_state;
   cap_state_t        next_cap_state;
   logic              rise;
   logic              fall;
   logic              act_edge;
   logic              int_tick;
   logic              tick;

   assign o_count        = count;
   assign o_overflow     = ovf;
   assign o_capture_done = cap_done;

   ////////////////////////////////////////////////////////////////////////
   // Second flop alone reads the first; edges come from flops two and three
   assign rise     = pin_s2 & ~pin_s3;                          // R19
   assign fall     = ~pin_s2 & pin_s3;                          // R19
   assign act_edge = i_edge_sel ? fall : rise;                  // R05 R17
   // Prescaler: divide by 2**psc, tick when low bits all ones
   assign int_tick = ((psc_cnt | ~((PSC_W'(1) << i_psc_ratio) - PSC_W'(1)))
                      == {PSC_W{1'b1}});                        // R16 R03

   always_comb begin
      next_psc_cnt   = psc_cnt + PSC_W'(1);
      next_preload   = preload;
      next_count     = count;
      next_ovf       = 1'b0;
      next_cap_done  = 1'b0;
      next_cap_state = cap_state;
      tick           = 1'b0;
      if (!i_run || i_op_mode == MODE_NONE || i_op_mode == MODE_EVENT) begin
         next_psc_cnt = '0;                                     // R04
      end
      unique case (i_op_mode)
         MODE_EVENT:   tick = i_run & act_edge;                 // R05 R04
         MODE_TIMER:   tick = i_run & int_tick;                 // R03 R07
         MODE_CAPTURE: tick = i_run & int_tick &
                              (cap_state == CAP_ACTIVE);        // R03
         default:      tick = 1'b0;                             // R15
      endcase
      // Capture sequence: high pulse starts on rise when edge bit set
      if (i_op_mode == MODE_CAPTURE && i_run) begin
         unique case (cap_state)
            CAP_IDLE:   next_cap_state = CAP_ARMED;
            CAP_ARMED:  if ((i_edge_sel ? rise : fall)) begin
               next_cap_state = CAP_ACTIVE;                     // R18
               next_psc_cnt   = '0;
            end
            CAP_ACTIVE: if ((i_edge_sel ? fall : rise)) begin
               next_cap_state = CAP_IDLE;                       // R18
               next_cap_done  = 1'b1;                           // R18
               tick           = 1'b0;
            end
         endcase
      end else begin
         next_cap_state = CAP_IDLE;                             // R18
      end
      if (tick) begin
         if (count == COUNT_FULL) begin
            next_count = preload;                               // R08
            next_ovf   = 1'b1;                                  // R08
         end else begin
            next_count = count + 8'h01;                         // R01
         end
      end
      if (i_preload_wr) begin
         next_preload = i_wdata;                                // R10
         if (!i_run) begin
            next_count = i_wdata;                               // R09
         end else if (tick && count == COUNT_FULL) begin
            next_count = i_wdata;                               // R10
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      pin_s1 <= i_ext_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (!i_rst_n) begin
         psc_cnt   <= '0;
         preload   <= COUNT_RESET;                              // R12
         count     <= COUNT_RESET;
         ovf       <= 1'b0;
         cap_done  <= 1'b0;
         cap_state <= CAP_IDLE;
      end else begin
         psc_cnt   <= next_psc_cnt;
         preload   <= next_preload;
         count     <= next_count;
         ovf       <= next_ovf;
         cap_done  <= next_cap_done;
         cap_state <= next_cap_state;
      end
   end
endmodule : timer_channel
`default_nettype wire

// file: src/dual_timer_pkg.sv
// Purpose: Shared constants for the dual timer/event counter block
// Assumes: 8-bit register port, one system clock
// Notes:   Offsets are word indexes on the plain register port
package dual_timer_pkg;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 3;
   localparam int          NUM_TMR       = 2;
   localparam int          PSC_W         = 7;
   // Register offsets
   localparam logic [2:0]  ADDR_TIMER0_COUNT_PRELOAD     = 3'h0;
   localparam logic [2:0]  ADDR_CTRL0    = 3'h1;
   localparam logic [2:0]  ADDR_TIMER1_COUNT_PRELOAD     = 3'h2;
   localparam logic [2:0]  ADDR_CTRL1    = 3'h3;
   localparam logic [2:0]  ADDR_IRQ_STAT = 3'h4;
   localparam logic [2:0]  ADDR_IRQ_MASK = 3'h5;
   // Control register fields
   localparam int          MODE_HI       = 7;
   localparam int          MODE_LO       = 6;
   localparam int          RUN_BIT       = 4;
   localparam int          EDGE_BIT      = 3;
   localparam int          PSC_HI        = 2;
   localparam int          PSC_LO        = 0;
   localparam logic [7:0]  CTRL_WMASK    = 8'hDF;
   localparam logic [7:0]  CTRL_RESET    = 8'h08;
   localparam logic [7:0]  COUNT_RESET   = 8'h00;
   localparam logic [7:0]  COUNT_FULL    = 8'hFF;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   localparam logic [1:0]  MODE_NONE     = 2'h0;
   localparam logic [1:0]  MODE_EVENT    = 2'h1;
   localparam logic [1:0]  MODE_TIMER    = 2'h2;
   localparam logic [1:0]  MODE_CAPTURE  = 2'h3;
endpackage : dual_timer_pkg

// file: src/dual_timer_event_counter.sv
// Purpose: Two 8-bit timer/event counters with register port and interrupt
// Assumes: Synchronous active-low reset, pins synchronous to i_sys_clk
// Notes:   Read data appear the cycle after the read strobe
//
// Functional notes
// R01: Two independent 8-bit up counters
// R02: Mode field in control bits 7..6
// R03: Timer and capture use prescaled system clock
// R04: Prescaler ignored when pin clocks counter
// R05: Event mode counts selected pin edges
// R06: Edge select bit 3, event and capture
// R07: Run bit 4 starts and halts counting
// R08: Overflow past FFH reloads and interrupts
// R09: Preload write when stopped loads counter
// R10: Preload write when running waits overflow
// R11: Timer register read returns live count
// R12: Preload value undefined until written
// R13: Software clears preload for full range
// R14: Software programs control before use
// R15: Mode codes none, event, timer, capture
// R16: Prescale divides by two to field power
// R17: Edge bit picks falling edge, high pulse
// R18: Capture ends on return, clears run
// R19: Pin synchronised, one pulse per edge
`timescale 1ns/1ps
`default_nettype none
module dual_timer_event_counter (
   input  wire logic                                i_sys_clk,
   input  wire logic                                i_rst_n,
   input  wire logic [dual_timer_pkg::ADDR_W-1:0]   i_addr,
   input  wire logic [dual_timer_pkg::DATA_W-1:0]   i_wdata,
   input  wire logic                                i_wr,
   input  wire logic                                i_rd,
   input  wire logic [dual_timer_pkg::NUM_TMR-1:0]  i_ext_count_pin,
   output logic      [dual_timer_pkg::DATA_W-1:0]   o_rdata,
   output logic                                     o_irq
);
   import dual_timer_pkg::*;

   function automatic logic [ADDR_W-1:0] count_addr(input int n);
      count_addr = ADDR_W'(2 * n);
   endfunction : count_addr

   logic [7:0]          counter_control_reg [NUM_TMR];
   logic [7:0]          next_ctrl           [NUM_TMR];
   logic [7:0]          count_val           [NUM_TMR];
   logic [NUM_TMR-1:0]  ovf_evt;
   logic [NUM_TMR-1:0]  cap_evt;
   logic [NUM_TMR-1:0]  preload_wr;
   logic [NUM_TMR-1:0]  irq_stat;
   logic [NUM_TMR-1:0]  next_irq_stat;
   logic [NUM_TMR-1:0]  irq_mask;
   logic [NUM_TMR-1:0]  next_irq_mask;
   logic [7:0]          rdata;
   logic [7:0]          next_rdata;
   logic                irq;
   logic                next_irq;

   assign o_rdata = rdata;
   assign o_irq   = irq;

   ////////////////////////////////////////////////////////////////////////
   // Channels
   generate
      for (genvar n = 0; n < NUM_TMR; n++) begin : g_chan
         assign preload_wr[n] = i_wr && (i_addr == count_addr(n));
         timer_channel u_chan (
            .i_sys_clk      (i_sys_clk),
            .i_rst_n        (i_rst_n),
            .i_op_mode      (counter_control_reg[n][MODE_HI:MODE_LO]), // R02
            .i_run          (counter_control_reg[n][RUN_BIT]),         // R07
            .i_edge_sel     (counter_control_reg[n][EDGE_BIT]),        // R06
            .i_psc_ratio    (counter_control_reg[n][PSC_HI:PSC_LO]),   // R03
            .i_ext_pin      (i_ext_count_pin[n]),
            .i_preload_wr   (preload_wr[n]),
            .i_wdata        (i_wdata),
            .o_count        (count_val[n]),
            .o_overflow     (ovf_evt[n]),
            .o_capture_done (cap_evt[n])
         );

         always_comb begin
            next_ctrl[n] = counter_control_reg[n];
            if (i_wr && (i_addr == count_addr(n) + ADDR_W'(1))) begin
               next_ctrl[n] = i_wdata & CTRL_WMASK;
            end
            // Hardware clear wins only when no write lands the same cycle
            if (cap_evt[n] && !(i_wr &&
                (i_addr == count_addr(n) + ADDR_W'(1)))) begin
               next_ctrl[n][RUN_BIT] = 1'b0;                    // R18
            end
         end

         always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
               counter_control_reg[n] <= CTRL_RESET;
            end else begin
               counter_control_reg[n] <= next_ctrl[n];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and register read
   always_comb begin
      next_irq_stat = irq_stat;
      next_irq_mask = irq_mask;
      if (i_wr && i_addr == ADDR_IRQ_STAT) begin
         next_irq_stat = irq_stat & ~i_wdata[NUM_TMR-1:0];
      end
      if (i_wr && i_addr == ADDR_IRQ_MASK) begin
         next_irq_mask = i_wdata[NUM_TMR-1:0];
      end
      // Set after clear so a same-cycle event is never lost
      next_irq_stat = next_irq_stat | ovf_evt;                  // R08
      next_irq      = |(next_irq_stat & next_irq_mask);
      next_rdata    = ZERO_BYTE;
      if (i_rd) begin
         unique case (i_addr)
            ADDR_TIMER0_COUNT_PRELOAD:     next_rdata = count_val[0];           // R11
            ADDR_CTRL0:    next_rdata = counter_control_reg[0];
            ADDR_TIMER1_COUNT_PRELOAD:     next_rdata = count_val[1];           // R11
            ADDR_CTRL1:    next_rdata = counter_control_reg[1];
            ADDR_IRQ_STAT: next_rdata = {6'h00, irq_stat};
            ADDR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
            default:       next_rdata = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq      <= 1'b0;
         rdata    <= ZERO_BYTE;
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         irq      <= next_irq;
         rdata    <= next_rdata;
      end
   end
endmodule : dual_timer_event_counter
`default_nettype wire

// file: test/timer_props_chk_properties.sv
// Purpose: Port assertions for the dual timer/event counter
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module timer_props_chk
   import dual_timer_pkg::*;
(
   input wire logic       i_sys_clk,
   input wire logic       i_rst_n,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [1:0] i_ext_count_pin,
   input wire logic [7:0] o_rdata,
   input wire logic       o_irq
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence rd_of(logic [2:0] ad);
      i_rd && i_addr == ad;
   endsequence
   sequence wr_of(logic [2:0] ad);
      i_wr && i_addr == ad;
   endsequence
   rdata_idle_a: assert property (!i_rd |=> o_rdata == ZERO_BYTE)
      else $error("read data not idle");
   unmapped_rd_a: assert property ((i_rd && i_addr > ADDR_IRQ_MASK)
      |=> o_rdata == ZERO_BYTE) else $error("unmapped read not zero");
   ctrl_gap_a: assert property ((rd_of(ADDR_CTRL0) or rd_of(ADDR_CTRL1))
      |=> !o_rdata[5]) else $error("control bit 5 set");
   // Capture may drop run on its own, so that mode is left out
   ctrl_back_a: assert property ((wr_of(ADDR_CTRL0) ##0 i_wdata[7:6] !=
      MODE_CAPTURE) ##1 rd_of(ADDR_CTRL0) |=> o_rdata ==
      ($past(i_wdata, 2) & CTRL_WMASK)) else $error("control readback");
   mask_back_a: assert property (wr_of(ADDR_IRQ_MASK) ##1
      rd_of(ADDR_IRQ_MASK) |=> o_rdata[1:0] == $past(i_wdata[1:0], 2))
      else $error("mask readback");
   irq_off_a: assert property ((wr_of(ADDR_IRQ_MASK) ##0
      i_wdata == ZERO_BYTE) |=> ##1 !o_irq) else $error("masked irq high");
   irq_cause_a: assert property ((rd_of(ADDR_IRQ_STAT) ##0
      (o_irq && !$past(i_wr))) |=> o_rdata[1:0] != 2'h0)
      else $error("irq without status");
   reset_quiet_a: assert property ($rose(i_rst_n)
      |-> !o_irq && o_rdata == ZERO_BYTE) else $error("not quiet at reset");
endmodule : timer_props_chk
bind dual_timer_event_counter timer_props_chk timer_props_chk_i (
   .i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
   .i_ext_count_pin, .o_rdata, .o_irq
);
`default_nettype wire

// file: test/ext_pin_source.sv
// Purpose: Pulse and event source on the two timer pins
// Assumes: Pins are driven levels with no pull resistor
// Notes:   Each level holds until the next call
`timescale 1ns/1ps
`default_nettype none
module ext_pin_source (
   input  wire logic       i_sys_clk,
   output logic      [1:0] o_pin
);
   initial o_pin = 2'h0;
   task automatic set(input int n, input logic v);
      o_pin[n] <= v;
   endtask : set
   // High pulse of w clocks, then back to the idle low level
   task automatic pulse(input int n, input int w);
      o_pin[n] <= 1'b1;
      repeat (w) @(posedge i_sys_clk);
      o_pin[n] <= 1'b0;
   endtask : pulse
endmodule : ext_pin_source
`default_nettype wire

// file: test/testbench.sv
// Purpose: Self-checking bench for the dual timer/event counter
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Pin edges need a few cycles through the synchroniser
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
   n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module testbench;
   import dual_timer_pkg::*;
   logic       i_sys_clk;
   logic       i_rst_n;
   logic [2:0] i_addr;
   logic [7:0] i_wdata;
   logic       i_wr;
   logic       i_rd;
   logic [1:0] pin;
   logic [7:0] o_rdata;
   logic       o_irq;
   logic [7:0] a;
   logic [7:0] b;
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         cyc = 0;
   dual_timer_event_counter dual_timer_event_counter_i (.i_sys_clk,
      .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_ext_count_pin(pin),
      .o_rdata, .o_irq);
   ext_pin_source ext_pin_source_i (.i_sys_clk, .o_pin(pin));
   ////////////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // An idle cycle follows each strobe, so no strobe is set twice at once
   task wr(input logic [2:0] ad, input logic [7:0] d);
      i_wr <= 1'b1;
      i_addr <= ad;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      @(posedge i_sys_clk);
   endtask : wr
   // Read data are taken mid-cycle, where they have settled
   task rd(input logic [2:0] ad, output logic [7:0] d);
      i_rd <= 1'b1;
      i_addr <= ad;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk);
      d = o_rdata;
      @(posedge i_sys_clk);
   endtask : rd
   task t_reset;
      for (int k = 0; k < 8; k++) begin
         rd(3'(k), a);
         `CHK("reset", (k == 1 || k == 3) ? CTRL_RESET : ZERO_BYTE, a)
      end
      wr(3'h6, 8'hFF);
      rd(3'h6, a);
      `CHK("unmapped", ZERO_BYTE, a)
   endtask : t_reset
   task t_psc;
      wr(ADDR_TIMER0_COUNT_PRELOAD, ZERO_BYTE);
      for (int p = 0; p < 8; p++) begin
         wr(ADDR_CTRL0, 8'h90 | 8'(p));
         rd(ADDR_TIMER0_COUNT_PRELOAD, a);
         repeat ((4 << p) - 2) @(posedge i_sys_clk);
         rd(ADDR_TIMER0_COUNT_PRELOAD, b);
         `CHK("ticks", 8'h04, b - a)
      end
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CTRL0, k ? 8'h82 : 8'h10);
         repeat (2) @(posedge i_sys_clk);
         rd(ADDR_TIMER0_COUNT_PRELOAD, a);
         repeat (9) @(posedge i_sys_clk);
         rd(ADDR_TIMER0_COUNT_PRELOAD, b);
         `CHK("halted", a, b)
      end
   endtask : t_psc
   task t_ovf;
      wr(ADDR_CTRL0, 8'h80);
      wr(ADDR_TIMER0_COUNT_PRELOAD, 8'hF0);
      rd(ADDR_TIMER0_COUNT_PRELOAD, a);
      `CHK("stopped load", 8'hF0, a)
      wr(ADDR_IRQ_MASK, 8'h01);
      rd(ADDR_IRQ_MASK, a);
      `CHK("mask", 8'h01, a)
      wr(ADDR_CTRL0, 8'h90);
      rd(ADDR_CTRL0, a);
      `CHK("control", 8'h90, a)
      wr(ADDR_TIMER0_COUNT_PRELOAD, 8'h80);
      rd(ADDR_TIMER0_COUNT_PRELOAD, a);
      `CHK("live count", 1'b1, a > 8'hF0 && a < 8'hF8)
      for (int k = 0; k < 40 && o_irq !== 1'b1; k++) @(negedge i_sys_clk);
      @(posedge i_sys_clk);
      `CHK("irq", 1'b1, o_irq)
      rd(ADDR_IRQ_STAT, a);
      `CHK("status", 8'h01, a)
      rd(ADDR_TIMER0_COUNT_PRELOAD, a);
      `CHK("reload", 1'b1, a >= 8'h80 && a < 8'hA0)
      wr(ADDR_IRQ_MASK, ZERO_BYTE);
      wr(ADDR_CTRL0, 8'h80);
      wr(ADDR_IRQ_STAT, 8'h01);
      rd(ADDR_IRQ_STAT, a);
      `CHK("cleared", ZERO_BYTE, a)
      `CHK("irq off", 1'b0, o_irq)
   endtask : t_ovf
   task t_evt;
      wr(ADDR_CTRL1, 8'h47);
      wr(ADDR_TIMER1_COUNT_PRELOAD, ZERO_BYTE);
      wr(ADDR_CTRL1, 8'h57);
      for (int k = 0; k < 4; k++) begin
         if (k == 2) wr(ADDR_CTRL1, 8'h5F);
         ext_pin_source_i.set(1, ~k[0]);
         repeat (6) @(posedge i_sys_clk);
         rd(ADDR_TIMER1_COUNT_PRELOAD, a);
         `CHK("events", (k == 3) ? 8'h02 : 8'h01, a)
      end
   endtask : t_evt
   task t_cap;
      wr(ADDR_CTRL1, 8'hC8);
      wr(ADDR_TIMER1_COUNT_PRELOAD, ZERO_BYTE);
      wr(ADDR_CTRL1, 8'hD8);
      ext_pin_source_i.pulse(1, 20);
      repeat (6) @(posedge i_sys_clk);
      rd(ADDR_TIMER1_COUNT_PRELOAD, b);
      `CHK("width", 1'b1, b >= 8'h13 && b <= 8'h15)
      rd(ADDR_CTRL1, a);
      `CHK("run cleared", 8'hC8, a)
      ext_pin_source_i.pulse(1, 20);
      repeat (6) @(posedge i_sys_clk);
      rd(ADDR_TIMER1_COUNT_PRELOAD, a);
      `CHK("ignored", b, a)
   endtask : t_cap
   ////////////////////////////////////////////////////////////////////
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done;
      end
   end
   initial begin
      i_rst_n = 1'b0;
      i_addr = 3'h0;
      i_wdata = 8'h00;
      i_wr = 1'b0;
      i_rd = 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      @(posedge i_sys_clk);
      t_reset;
      t_psc;
      t_ovf;
      t_evt;
      t_cap;
      test_done;
   end
endmodule : testbench
`default_nettype wire
